// ==== hw/sir_cfg.svh ====
`ifndef SIR_CFG_SVH
`define SIR_CFG_SVH

// register offsets on the internal register port
`define SIR_ADDR_WAKE_CTRL 8'h2C
`define SIR_ADDR_SRC_EN 8'h2D
`define SIR_ADDR_ROUTE 8'h2E
`define SIR_ADDR_SOURCE 8'h0C

// wake/pin control field positions
`define SIR_BIT_WAKE_TRANS 6
`define SIR_BIT_WAKE_ORIENT 5
`define SIR_BIT_WAKE_PULSE 4
`define SIR_BIT_WAKE_FALL 3
`define SIR_BIT_LEVEL 1
`define SIR_BIT_DRIVE 0

// source positions shared by enable, routing and source registers
`define SIR_SRC_ASLP 7
`define SIR_SRC_TRANS 5
`define SIR_SRC_ORIENT 4
`define SIR_SRC_PULSE 3
`define SIR_SRC_FALL 2
`define SIR_SRC_DRDY 0

// writable bit masks, unused positions read zero; wake-capable source mask
`define SIR_MASK_WAKE_CTRL 8'h7B
`define SIR_MASK_SRC 8'hBD
`define SIR_MASK_WAKE_SRC 8'h3C

// reset values
`define SIR_RST_WAKE_CTRL 8'h00
`define SIR_RST_SRC_EN 8'h00
`define SIR_RST_ROUTE 8'h00

`endif

// ==== hw/sir_pkg.sv ====
package sir_pkg;
    // register byte type
    typedef logic [7:0] sir_byte_t;
    // pad drive style
    typedef enum logic [1:0] {
        SIR_DRIVE_PUSH = 2'h1,
        SIR_DRIVE_OPEN = 2'h2
    } sir_drive_t;
endpackage

// ==== hw/sir_pad.sv ====
`timescale 1ns/1ps
`include "sir_cfg.svh"

// one interrupt pad: polarity, drive style and registered outputs
module sir_pad (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    input wire logic assert_i,
    input wire logic level_high_i,
    input wire logic open_drain_i,
    // pad
    output logic pad_o,
    output logic pad_oe_o
);
    logic pad_reg;
    logic pad_next;
    logic oe_reg;
    logic oe_next;

    // level and enable for the pad
    always_comb begin
        if (open_drain_i) begin
            // open drain only ever pulls to the active level
            pad_next = level_high_i;
            oe_next = assert_i;
        end else begin
            pad_next = assert_i ? level_high_i : ~level_high_i;
            oe_next = 1'b1;
        end
    end

    // registered pad, reset gives idle push-pull active-low high level
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pad_reg <= 1'b1;
            oe_reg <= 1'b1;
        end else begin
            pad_reg <= pad_next;
            oe_reg <= oe_next;
        end
    end

    assign pad_o = pad_reg;
    assign pad_oe_o = oe_reg;
endmodule // sir_pad

// ==== hw/sir_router.sv ====
`timescale 1ns/1ps
`include "sir_cfg.svh"

module sir_router (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // register port from the serial interface block
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // event flags from the functional blocks, same positions as enables
    input wire logic [7:0] event_flags_i,
    // sleep state from the system mode logic
    input wire logic sleeping_i,
    // wake request to the system mode logic
    output logic wake_req_o,
    // first interrupt pad
    output logic irq_pin_first_o,
    output logic irq_pin_first_oe_o,
    // second interrupt pad
    output logic irq_pin_second_o,
    output logic irq_pin_second_oe_o
);
    // wake/pin control register
    sir_pkg::sir_byte_t wake_source_and_pin_control_reg;
    sir_pkg::sir_byte_t wake_source_and_pin_control_next;
    // source enable register
    sir_pkg::sir_byte_t interrupt_source_enables_reg;
    sir_pkg::sir_byte_t interrupt_source_enables_next;
    // routing register
    sir_pkg::sir_byte_t interrupt_pin_routing_reg;
    sir_pkg::sir_byte_t interrupt_pin_routing_next;
    // read data register
    sir_pkg::sir_byte_t rdata_reg;
    sir_pkg::sir_byte_t rdata_next;
    // wake request register
    logic wake_reg;
    logic wake_next;
    // derived combinational terms
    sir_pkg::sir_byte_t gated_src;
    logic first_any;
    logic second_any;
    // named fields of the wake/pin control register
    logic irq_level_select;
    logic irq_drive_mode;
    // pad style kept as an enum for readable compares
    sir_pkg::sir_drive_t drive_style;
    sir_pkg::sir_byte_t wake_sel;

    // register write decode
    always_comb begin
        wake_source_and_pin_control_next = wake_source_and_pin_control_reg;
        interrupt_source_enables_next = interrupt_source_enables_reg;
        interrupt_pin_routing_next = interrupt_pin_routing_reg;
        // hold every register unless a write hits it
        if (reg_wr_i) begin
            case (reg_addr_i)
                // unused bits dropped
                // wake sources, polarity and drive style
                `SIR_ADDR_WAKE_CTRL: begin
                    wake_source_and_pin_control_next = reg_wdata_i & `SIR_MASK_WAKE_CTRL;
                end
                // per-source enables
                `SIR_ADDR_SRC_EN: begin
                    interrupt_source_enables_next = reg_wdata_i & `SIR_MASK_SRC;
                end
                // pin routing, one bit per source
                `SIR_ADDR_ROUTE: begin
                    interrupt_pin_routing_next = reg_wdata_i & `SIR_MASK_SRC;
                end
                // other addresses belong to other blocks
                default: begin
                end
            endcase
        end
    end

    // flags are levels and are not latched here, so a flag that drops
    // before the host reads the source view is gone from it
    // enables gate the flags
    assign gated_src = event_flags_i & interrupt_source_enables_reg & `SIR_MASK_SRC;

    // or of routed sources
    // both pins may assert together when sources are split
    assign first_any = |(gated_src & interrupt_pin_routing_reg);
    assign second_any = |(gated_src & ~interrupt_pin_routing_reg);

    // control fields
    assign irq_level_select = wake_source_and_pin_control_reg[`SIR_BIT_LEVEL];
    assign irq_drive_mode = wake_source_and_pin_control_reg[`SIR_BIT_DRIVE];
    assign drive_style = irq_drive_mode ? sir_pkg::SIR_DRIVE_OPEN : sir_pkg::SIR_DRIVE_PUSH;

    // wake select mapped onto source positions
    always_comb begin
        // autosleep, data ready and unused positions stay zero
        wake_sel = 8'h00;
        wake_sel[`SIR_SRC_TRANS] = wake_source_and_pin_control_reg[`SIR_BIT_WAKE_TRANS];
        wake_sel[`SIR_SRC_ORIENT] = wake_source_and_pin_control_reg[`SIR_BIT_WAKE_ORIENT];
        wake_sel[`SIR_SRC_PULSE] = wake_source_and_pin_control_reg[`SIR_BIT_WAKE_PULSE];
        wake_sel[`SIR_SRC_FALL] = wake_source_and_pin_control_reg[`SIR_BIT_WAKE_FALL];
    end

    // wake request, only while asleep
    // sleep level comes from this clock domain, so no sync stage
    always_comb begin
        wake_next = sleeping_i & (|(gated_src & wake_sel & `SIR_MASK_WAKE_SRC));
    end

    // readback; source register shows gated flags for the host
    always_comb begin
        // address is a level, data follows one cycle later
        case (reg_addr_i)
            // wake/pin control readback
            `SIR_ADDR_WAKE_CTRL: begin
                rdata_next = wake_source_and_pin_control_reg;
            end
            // enable readback
            `SIR_ADDR_SRC_EN: begin
                rdata_next = interrupt_source_enables_reg;
            end
            // routing readback
            `SIR_ADDR_ROUTE: begin
                rdata_next = interrupt_pin_routing_reg;
            end
            // source view for host
            // live view; several sources may share one pin
            `SIR_ADDR_SOURCE: begin
                rdata_next = gated_src;
            end
            // unmapped offsets read zero
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // control registers; reset leaves every source off and pins idle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wake_source_and_pin_control_reg <= `SIR_RST_WAKE_CTRL;
            interrupt_source_enables_reg <= `SIR_RST_SRC_EN;
            interrupt_pin_routing_reg <= `SIR_RST_ROUTE;
        end else begin
            // writes land here, visible on the next read
            wake_source_and_pin_control_reg <= wake_source_and_pin_control_next;
            interrupt_source_enables_reg <= interrupt_source_enables_next;
            interrupt_pin_routing_reg <= interrupt_pin_routing_next;
        end
    end

    // read data register, one cycle behind the address
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            // bus reads zero out of reset
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // wake request register; costs a cycle but never glitches
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            // no wake while reset holds
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= wake_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o = rdata_reg;
    assign wake_req_o = wake_reg;

    // polarity, drive, idle level
    // pads are registered, so a pin follows its cause one cycle late
    sir_pad u_pad_first (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .assert_i(first_any),
        .level_high_i(irq_level_select),
        .open_drain_i(drive_style == sir_pkg::SIR_DRIVE_OPEN),
        .pad_o(irq_pin_first_o),
        .pad_oe_o(irq_pin_first_oe_o)
    );

    // second pad, same treatment
    sir_pad u_pad_second (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .assert_i(second_any),
        .level_high_i(irq_level_select),
        .open_drain_i(drive_style == sir_pkg::SIR_DRIVE_OPEN),
        .pad_o(irq_pin_second_o),
        .pad_oe_o(irq_pin_second_oe_o)
    );
endmodule // sir_router

// ==== test/sir_host_model.sv ====
`timescale 1ns/1ps

// host side of the two interrupt wires, each with a pull-up
module sir_host_model (
    // pads from the device
    input wire logic pin1_i,
    input wire logic pin1_oe_i,
    input wire logic pin2_i,
    input wire logic pin2_oe_i,
    // level the host treats as asserted
    input wire logic level_high_i,
    // interrupt seen on each wire
    output logic irq1_o,
    output logic irq2_o
);
    // a released wire is pulled up, never left at the last value
    // host notices the wire, then reads the source byte
    assign irq1_o = ((pin1_oe_i ? pin1_i : 1'b1) == level_high_i);
    assign irq2_o = ((pin2_oe_i ? pin2_i : 1'b1) == level_high_i);
endmodule // sir_host_model

// ==== test/sir_router_asserts.sv ====
`timescale 1ns/1ps

// port checker built on shadow copies of the control registers
module sir_router_asserts (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // events, sleep and pads
    input wire logic [7:0] event_flags_i,
    input wire logic sleeping_i,
    input wire logic wake_req_o,
    input wire logic irq_pin_first_o,
    input wire logic irq_pin_first_oe_o,
    input wire logic irq_pin_second_o,
    input wire logic irq_pin_second_oe_o
);
    logic [7:0] wk_reg, en_reg, rt_reg, rd_exp; // shadows, read view
    logic a1, a2, pol, od, wk; // pin demand, pad style, wake
    // shadows follow writes with unused bits dropped
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wk_reg <= 8'h00;
            en_reg <= 8'h00;
            rt_reg <= 8'h00;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 8'h2C) wk_reg <= reg_wdata_i & 8'h7B;
            if (reg_addr_i == 8'h2D) en_reg <= reg_wdata_i & 8'hBD;
            if (reg_addr_i == 8'h2E) rt_reg <= reg_wdata_i & 8'hBD;
        end
    end
    // expected demand; only the four motion functions may wake
    always_comb begin
        a1 = |(event_flags_i & en_reg & rt_reg);
        a2 = |(event_flags_i & en_reg & ~rt_reg);
        pol = wk_reg[1];
        od = wk_reg[0];
        wk = sleeping_i & |(event_flags_i[5:2] & en_reg[5:2] & wk_reg[6:3]);
        case (reg_addr_i)
            8'h2C: rd_exp = wk_reg;
            8'h2D: rd_exp = en_reg;
            8'h2E: rd_exp = rt_reg;
            8'h0C: rd_exp = event_flags_i & en_reg;
            default: rd_exp = 8'h00;
        endcase
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_first_active: assert property (a1 |=> irq_pin_first_o == $past(pol)
        && irq_pin_first_oe_o) else $error("first pin not asserted");
    chk_second_active: assert property (a2 |=> irq_pin_second_o == $past(pol)
        && irq_pin_second_oe_o) else $error("second pin not asserted");
    chk_first_idle: assert property (!a1 && !od |=> irq_pin_first_o != $past(pol)
        && irq_pin_first_oe_o) else $error("first pin not idle");
    chk_second_idle: assert property (!a2 && !od |=> irq_pin_second_o != $past(pol)
        && irq_pin_second_oe_o) else $error("second pin not idle");
    chk_open_release: assert property (od && !a1 && !a2 |=> !irq_pin_first_oe_o
        && !irq_pin_second_oe_o) else $error("open drain pad driven");
    chk_wake_match: assert property (wake_req_o == $past(wk))
        else $error("wake request wrong");
    chk_read_back: assert property (reg_rdata_o == $past(rd_exp))
        else $error("read data wrong");
    chk_reset_state: assert property ($rose(rst_n_i) |-> reg_rdata_o == 8'h00
        && !wake_req_o && irq_pin_first_o && irq_pin_second_o) else $error("bad reset state");
    cover property (a1 && pol);
    cover property (wake_req_o);
    cover property (od && a2);
endmodule // sir_router_asserts

bind sir_router sir_router_asserts i_sir_router_asserts (.*);

// ==== test/tb_sir_router.sv ====
`timescale 1ns/1ps

// self-checking bench for the interrupt router
module tb_sir_router;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic sleeping_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] event_flags_i = 8'h00;
    logic [7:0] reg_rdata_o, pads;
    logic wake_req_o, irq_pin_first_o, irq_pin_first_oe_o, irq_pin_second_o;
    logic irq_pin_second_oe_o, irq1, irq2;
    int fail_count = 0;
    int total_checks = 0;
    // wake ctrl, enables, routing, flags, sleep, {o1,oe1,o2,oe2,wake}
    logic [37:0] rows [12] = '{
        {8'h00, 8'hBD, 8'hBD, 8'h20, 1'b0, 5'h0E}, {8'h02, 8'hBD, 8'h00, 8'h01, 1'b0, 5'h0E},
        {8'h01, 8'h00, 8'hFF, 8'hFF, 1'b0, 5'h00}, {8'h7B, 8'hBD, 8'h04, 8'h04, 1'b1, 5'h1D},
        {8'h43, 8'hBD, 8'h00, 8'h18, 1'b1, 5'h16}, {8'h7B, 8'hBD, 8'h80, 8'h81, 1'b1, 5'h1E},
        {8'h40, 8'h20, 8'h00, 8'h20, 1'b1, 5'h1B}, {8'h20, 8'h10, 8'h10, 8'h10, 1'b1, 5'h0F},
        {8'h10, 8'h08, 8'h08, 8'h08, 1'b1, 5'h0F}, {8'h78, 8'hBD, 8'h00, 8'h3C, 1'b0, 5'h1A},
        {8'h20, 8'hBD, 8'h20, 8'h20, 1'b1, 5'h0E}, {8'h01, 8'hBD, 8'h01, 8'h01, 1'b0, 5'h08}};
    assign pads = {3'h0, irq_pin_first_o, irq_pin_first_oe_o, irq_pin_second_o,
                   irq_pin_second_oe_o, wake_req_o};
    always #20 clock_i = ~clock_i;
    sir_router i_sir_router (.*);
    sir_host_model i_sir_host_model (.pin1_i(irq_pin_first_o), .pin1_oe_i(irq_pin_first_oe_o),
        .pin2_i(irq_pin_second_o), .pin2_oe_i(irq_pin_second_oe_o), .level_high_i(1'b0),
        .irq1_o(irq1), .irq2_o(irq2));
    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write strobe, released before the next can start
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask
    // read data is registered, so look one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        reg_addr_i = a;
        @(negedge clock_i);
        check(reg_rdata_o, exp);
    endtask
    task automatic do_reset;
        @(negedge clock_i);
        rst_n_i = 1'b0;
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        check(pads, 8'h1E);
        rd(8'h2C, 8'h00);
        rd(8'h2D, 8'h00);
        rd(8'h2E, 8'h00);
        wr(8'h2C, 8'hFF);
        wr(8'h2D, 8'hFF);
        wr(8'h2E, 8'hFF);
        rd(8'h2C, 8'h7B);
        rd(8'h2D, 8'hBD);
        rd(8'h2E, 8'hBD);
        rd(8'h2F, 8'h00);
        foreach (rows[i]) begin
            wr(8'h2C, rows[i][37:30]);
            wr(8'h2D, rows[i][29:22]);
            wr(8'h2E, rows[i][21:14]);
            event_flags_i = rows[i][13:6];
            sleeping_i = rows[i][5];
            repeat (2) @(negedge clock_i);
            check(pads, {3'h0, rows[i][4:0]});
        end
        // host finds the first wire already low from the last row, then asks who raised it
        wr(8'h2C, 8'h00);
        wr(8'h2E, 8'hFF);
        event_flags_i = 8'h66;
        for (int n = 0; n < 8 && irq1 !== 1'b1; n++) @(negedge clock_i);
        if (irq1 !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: no interrupt seen", $time);
        end
        rd(8'h0C, 8'h24);
        check({7'h00, irq2}, 8'h00);
        do_reset();
        check(pads, 8'h1E);
        rd(8'h2D, 8'h00);
        tally_and_finish();
    end
endmodule // tb_sir_router
